// [design/wdt_params.svh]
// register offsets, field positions, reset values and counts for the watchdog
`ifndef WDT_PARAMS_SVH
`define WDT_PARAMS_SVH
`define WDT_MODE_ADDR 16'hff48
`define WDT_KICK_ADDR 16'hff49
`define WDT_MODE_RESET 8'h67
`define WDT_KICK_READ 8'h9a
`define WDT_KICK_KEY 8'hac
`define WDT_CS_HI_BIT 4
`define WDT_CS_LO_BIT 3
`define WDT_FIXED_BITS 8'h60
`define WDT_SLOW_BASE_EXP 11
`define WDT_SYS_BASE_EXP 13
`define WDT_CNT_WIDTH 21
`define WDT_RESET_CAUSE_REGISTER_WDT_BIT 4
`endif

// [design/wdt_pkg.sv]
// types shared by the watchdog design files
package wdt_pkg;
  typedef enum logic [1:0] {
    wdt_src_slow,
    wdt_src_sys,
    wdt_src_stop
  } wdt_src_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic bit_op;
    logic [15:0] addr;
    logic [7:0] wdata;
  } wdt_bus_t;
endpackage

// [design/wdt_tick.sv]
// count-clock qualifier: picks the enabled tick for the selected source
`timescale 1ns/1ps
module wdt_tick
  import wdt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic slow_osc_tick,
  input wire logic sys_clock_tick,
  input wire wdt_src_t src,
  input wire logic paused,
  output logic tick
);
  typedef struct packed {
    logic tick;
  } wdt_tick_state_t;

  wdt_tick_state_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    case (src)
      wdt_src_slow: s_d.tick = slow_osc_tick & ~paused;
      wdt_src_sys: s_d.tick = sys_clock_tick & ~paused;
      default: s_d.tick = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;
endmodule

// [design/wdt_core.sv]
// watchdog timer: mode and kick registers, counter, overflow and misuse reset
//
// Contract
// R1 - reset loads mode 67h, counting starts
// R2 - second mode write requests reset instead
// R3 - bits 4:3 pick slow, system, or stop
// R4 - interval n: 2^(11+n) slow, 2^(13+n) system
// R5 - interval field resets to all ones
// R6 - software writes bits 7:5 as 011
// R7 - software writes mode only by byte
// R8 - non-stoppable option forces slow clock source
// R9 - mode write clears the counter
// R10 - key ach to kick clears counter
// R11 - wrong kick value requests reset
// R12 - bit operation on kick requests reset
// R13 - kick register always reads 9ah
// R14 - non-stoppable: keep counting during stop
// R15 - overflow requests reset
// R16 - software kicks from aux timer in stop
// R17 - software picks interval covering flash erase
// R18 - watchdog reset sets reset-cause bit 4
// R19 - stoppable: pause in halt/stop, hold count
// R20 - stopped watchdog ignores misuse resets
// R21 - binary counter with tap compare
`timescale 1ns/1ps
`include "wdt_params.svh"
module wdt_core
  import wdt_pkg::*;
#(
  parameter int CNT_WIDTH = `WDT_CNT_WIDTH
)
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire wdt_bus_t bus,
  input wire logic non_stoppable_opt,
  input wire logic slow_osc_tick,
  input wire logic sys_clock_tick,
  input wire logic halt_mode,
  input wire logic stop_mode,
  output logic [7:0] rdata,
  output logic wdt_reset_req,
  output logic watchdog_reset_flag,
  output logic [7:0] watchdog_mode_reg
);
  typedef struct packed {
    logic [7:0] mode;
    logic mode_written;
    logic [CNT_WIDTH-1:0] count;
    logic [7:0] rdata;
    logic reset_req;
    logic reset_flag;
  } wdt_state_t;

  wdt_state_t s_q, s_d;
  wdt_src_t src;
  logic paused;
  logic tick;
  logic stopped;
  logic mode_hit, kick_hit;
  logic misuse;
  logic overflow;

  // source decode shared by the tick path and the misuse gating
  function automatic wdt_src_t decode_src(input logic [7:0] mode, input logic fixed_slow);
    if (fixed_slow) begin
      decode_src = wdt_src_slow; // R8
    end else if (mode[`WDT_CS_HI_BIT]) begin
      decode_src = wdt_src_stop; // R3
    end else if (mode[`WDT_CS_LO_BIT]) begin
      decode_src = wdt_src_sys; // R3
    end else begin
      decode_src = wdt_src_slow; // R3
    end
  endfunction

  // overflow tap index for interval n and source
  function automatic int unsigned tap_index(input logic [2:0] n, input wdt_src_t s);
    if (s == wdt_src_sys) begin
      tap_index = `WDT_SYS_BASE_EXP + int'(n); // R4
    end else begin
      tap_index = `WDT_SLOW_BASE_EXP + int'(n); // R4
    end
  endfunction

  assign src = decode_src(s_q.mode, non_stoppable_opt);
  assign stopped = (src == wdt_src_stop);
  // non-stoppable keeps running in stop; halt then only matters when stoppable
  assign paused = non_stoppable_opt ? 1'b0 : (halt_mode | stop_mode); // R14 R19

  wdt_tick u_tick (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .slow_osc_tick(slow_osc_tick),
    .sys_clock_tick(sys_clock_tick),
    .src(src),
    .paused(paused),
    .tick(tick)
  );

  assign mode_hit = bus.wr && (bus.addr == `WDT_MODE_ADDR);
  assign kick_hit = bus.wr && (bus.addr == `WDT_KICK_ADDR);

  // misuse: second mode write, wrong key, any bit operation on kick
  always_comb begin
    misuse = 1'b0;
    if (!stopped) begin // R20
      if (mode_hit && s_q.mode_written) begin
        misuse = 1'b1; // R2
      end
      if (kick_hit && bus.bit_op) begin
        misuse = 1'b1; // R12
      end
      if (kick_hit && !bus.bit_op && bus.wdata != `WDT_KICK_KEY) begin
        misuse = 1'b1; // R11
      end
    end
  end

  // tap reached when bit k of the count is set, first at count 2^k
  assign overflow = !stopped && s_q.count[tap_index(s_q.mode[2:0], src)]; // R15 R21

  always_comb begin
    s_d = s_q;
    s_d.reset_req = 1'b0;
    if (tick && !stopped) begin
      s_d.count = s_q.count + 1'b1; // R21
    end
    if (mode_hit && !s_q.mode_written && !bus.bit_op) begin
      // fixed bits always read back as 011
      s_d.mode = (bus.wdata & 8'h1f) | `WDT_FIXED_BITS;
      s_d.mode_written = 1'b1;
      s_d.count = '0; // R9
    end
    if (kick_hit && !bus.bit_op && bus.wdata == `WDT_KICK_KEY) begin
      s_d.count = '0; // R10
    end
    if (misuse || overflow) begin
      s_d.reset_req = 1'b1; // R2 R11 R12 R15
      s_d.reset_flag = 1'b1; // R18
      s_d.count = '0;
    end
    if (bus.rd) begin
      case (bus.addr)
        `WDT_MODE_ADDR: s_d.rdata = s_q.mode;
        `WDT_KICK_ADDR: s_d.rdata = `WDT_KICK_READ; // R13
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // reset flag survives the requested reset only if rstn is not the chip reset;
  // the cause register outside latches it before the chip reset lands
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_q.mode <= `WDT_MODE_RESET; // R1 R5
      s_q.mode_written <= 1'b0;
      s_q.count <= '0;
      s_q.rdata <= 8'h00;
      s_q.reset_req <= 1'b0;
      s_q.reset_flag <= 1'b0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign wdt_reset_req = s_q.reset_req;
  assign watchdog_reset_flag = s_q.reset_flag;
  assign watchdog_mode_reg = s_q.mode;
endmodule

// [tb/wdt_core_properties.sv]
// port assertions for the watchdog core
`timescale 1ns/1ps
module wdt_core_properties
  import wdt_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic clk_en,
  input wire wdt_bus_t bus,
  input wire logic non_stoppable_opt,
  input wire logic [7:0] rdata,
  input wire logic wdt_reset_req,
  input wire logic watchdog_reset_flag,
  input wire logic [7:0] watchdog_mode_reg
);
  logic wrote_q;
  wire logic stop = watchdog_mode_reg[4] && !non_stoppable_opt;
  wire logic mw = clk_en && bus.wr && !bus.bit_op && bus.addr == 16'hff48;
  wire logic kw = clk_en && bus.wr && bus.addr == 16'hff49 && !stop;
  always_ff @(posedge clock or negedge rstn)
    if (!rstn) wrote_q <= 1'b0;
    else if (mw) wrote_q <= 1'b1;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rstn);
  property p_rd;
    clk_en && bus.rd && bus.addr == 16'hff49 |=> rdata == 8'h9a;
  endproperty
  a_rd: assert property (p_rd) else $error("kick read value");
  property p_key;
    kw && bus.wdata != 8'hac |=> wdt_reset_req;
  endproperty
  a_key: assert property (p_key) else $error("wrong key kept");
  property p_bit;
    kw && bus.bit_op |=> wdt_reset_req;
  endproperty
  a_bit: assert property (p_bit) else $error("bit access kept");
  property p_kick;
    kw && !bus.bit_op && bus.wdata == 8'hac |=> !wdt_reset_req [*2];
  endproperty
  a_kick: assert property (p_kick) else $error("good key reset");
  property p_once;
    mw && wrote_q && !stop |=> wdt_reset_req && $stable(watchdog_mode_reg);
  endproperty
  a_once: assert property (p_once) else $error("second mode write");
  property p_first;
    mw && !wrote_q |=> watchdog_mode_reg[7:5] == 3'b011 && !wdt_reset_req;
  endproperty
  a_first: assert property (p_first) else $error("first mode write");
  // two settled cycles of the stopped source
  sequence s_stopped;
    stop [*2];
  endsequence
  property p_quiet;
    s_stopped |=> !wdt_reset_req;
  endproperty
  a_quiet: assert property (p_quiet) else $error("reset while stopped");
  property p_flag;
    wdt_reset_req |=> watchdog_reset_flag [*2];
  endproperty
  a_flag: assert property (p_flag) else $error("cause flag lost");
  // clock enable low freezes the visible state
  property p_hold;
    !clk_en |=> $stable(watchdog_mode_reg) && $stable(watchdog_reset_flag);
  endproperty
  a_hold: assert property (p_hold) else $error("state moved while frozen");
endmodule
bind wdt_core wdt_core_properties u_wdt_core_properties (.clock, .rstn, .clk_en, .bus,
  .non_stoppable_opt, .rdata, .wdt_reset_req, .watchdog_reset_flag, .watchdog_mode_reg);

// [tb/wdt_core_tb.sv]
// self-checking bench for the watchdog core
`timescale 1ns/1ps
module wdt_core_tb
  import wdt_pkg::*;
;
  logic clock = 0, rstn = 0, opt = 0, halt_mode = 0, stop_mode = 0, req, flag;
  logic ce = 1, slow = 1, sys = 0;
  logic [7:0] rdata, mode;
  wdt_bus_t bus = '0;
  int n_fail = 0, n_tests = 0, n;
  always #2.5 clock = ~clock;
  wdt_core u_wdt_core (.clock, .rstn, .clk_en(ce), .bus, .non_stoppable_opt(opt),
    .slow_osc_tick(slow), .sys_clock_tick(sys), .halt_mode, .stop_mode, .rdata,
    .wdt_reset_req(req), .watchdog_reset_flag(flag), .watchdog_mode_reg(mode));
  task automatic chk(input logic [31:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: %h not %h", $time, g, e);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b);
    @(negedge clock);
    bus = '{wr: w, rd: !w, bit_op: b, addr: a, wdata: d};
    @(negedge clock);
    bus = '0;
  endtask
  task automatic rst;
    rstn = 0;
    repeat (4) @(negedge clock);
    rstn = 1;
  endtask
  // ticks every cycle, so intervals are counted in clocks
  task automatic meas(input int h, e);
    n = 0;
    while (req !== 1'b1 && n < 9000) begin
      @(negedge clock);
      n++;
      halt_mode = n >= 100 && n < 100 + h;
    end
    chk(n >= e - 2 && n <= e + 6, 1);
  endtask
  initial begin
    rst();
    chk(mode, 8'h67);
    acc(0, 16'hff49, 0, 0);
    chk(rdata, 8'h9a);
    acc(1, 16'hff49, 8'h55, 0);
    chk({req, flag}, 2'b11);
    acc(1, 16'hff49, 8'hac, 1);
    chk(req, 1);
    acc(1, 16'hff48, 8'h60, 0);
    chk(mode, 8'h60);
    acc(0, 16'hff48, 8'h00, 0);
    chk(rdata, 8'h60);
    acc(1, 16'hff48, 8'h67, 0);
    chk({req, mode}, 9'h160);
    acc(1, 16'hff49, 8'hac, 0);
    meas(3000, 5048);
    rst();
    // let the slow count run first so a missing clear shortens the period
    repeat (100) @(negedge clock);
    acc(1, 16'hff48, 8'h68, 0);
    slow = 0;
    sys = 1;
    meas(0, 8192);
    rst();
    acc(1, 16'hff48, 8'h70, 0);
    acc(1, 16'hff49, 8'h55, 1);
    acc(1, 16'hff48, 8'h60, 0);
    meas(0, 9000);
    opt = 1;
    stop_mode = 1;
    slow = 1;
    sys = 0;
    rst();
    acc(1, 16'hff48, 8'h70, 0);
    // kick period well inside the chosen interval
    repeat (3) begin
      repeat (1500) @(negedge clock);
      acc(1, 16'hff49, 8'hac, 0);
    end
    chk(flag, 0);
    ce = 0;
    repeat (3000) @(negedge clock);
    ce = 1;
    chk(flag, 0);
    meas(0, 2048);
    complete_run();
  end
  initial begin
    #400us;
    n_fail++;
    complete_run();
  end
endmodule
